/* shared/sss_map.vh */
// constants for the safe-state supervisor: register offsets, field positions, reset values, timing counts
// assumes a 25 MHz core clock and an Avalon-MM slave with 32-bit data, word-aligned byte addresses
//
// Notes on behaviour
// - faulted inputs read open or zero
// - safe state drives outputs open, zero
// - full power loss forces safe state
// - redundant supply loss flagged, not tripped
// - power loss, severe fault, power-up trip
// - self-test, diagnostics, application, override trip
// - only human release leaves safe state; the code also releases on a write of the CTRL release bit
// - safe state latched until human release; a write of the CTRL release bit also clears it
// - wrong module type holds safe state
// - watchdog expiry counts as failure
// - CRC mismatch counts as failure
// - tuning port enabled only by keyswitch
// - discard inbound except tuning in tuning
// - tuning mode holds trip outputs safe
// - monitoring link transmit only
// - configuration checks before release allowed
// - override beats application and platform commands
`ifndef SSS_MAP_VH
`define SSS_MAP_VH

// ----------------------------------------------------------------
// register offsets (byte addresses)
// ----------------------------------------------------------------
`define SSS_REG_CTRL      4'h0
`define SSS_REG_STATUS    4'h4
`define SSS_REG_OUTCMD    4'h8
`define SSS_REG_SUBSEL    4'hc

// ----------------------------------------------------------------
// control register fields
// ----------------------------------------------------------------
`define SSS_CTRL_APPTRIP  0
`define SSS_CTRL_RELEASE  1
`define SSS_CTRL_RESET    32'h0000_0001

// ----------------------------------------------------------------
// status register fields
// ----------------------------------------------------------------
`define SSS_ST_LATCHED    0
`define SSS_ST_TRIPNOW    1
`define SSS_ST_SUPPLYFLAG 2
`define SSS_ST_WDOG       3
`define SSS_ST_CRC        4
`define SSS_ST_TUNING     5
`define SSS_ST_STARTOK    6

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define SSS_CLK_MHZ       25
`define SSS_WDOG_US       1000
`define SSS_WDOG_CYCLES   (`SSS_WDOG_US * `SSS_CLK_MHZ)

`endif

/* sim/sss_checker_assertions.sv */
// checker: port relations of the safe-state supervisor
// assumes it is bound onto sss_safe_state_supervisor, one clock domain
`timescale 1ns/10ps
`default_nettype none
module sss_checker (
  // clock, reset, trip causes and release inputs
  input wire logic       core_clk,
  input wire logic       rst_n,
  input wire logic       powerGood,
  input wire logic       severeFault,
  input wire logic       platformDiagTrip,
  input wire logic       safetyOverrideKey,
  input wire logic       tuningKey,
  input wire logic       releaseButton,
  input wire logic       avsWrite,
  // observed outputs
  input wire logic [7:0] fieldOut,
  input wire logic       safeState,
  input wire logic       tuningPortEnable,
  input wire logic       tuningAccValid
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  logic [3:0] relAge_q; // cycles since last release activity, saturating
  // ----------------------------------------------------------------
  // release age counter
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) relAge_q <= 4'hf;
    else if (releaseButton || avsWrite) relAge_q <= 4'h0;
    else if (relAge_q != 4'hf) relAge_q <= relAge_q + 4'h1;
  end
  a_safe_out_zero: assert property (safeState [*2] |-> fieldOut == 8'h00)
    else $error("field outputs driven in safe state");
  a_power_loss_trip: assert property (!powerGood |-> ##[1:6] safeState)
    else $error("power loss did not trip");
  a_severe_trip: assert property (severeFault |-> ##[1:6] safeState)
    else $error("severe fault did not trip");
  a_diag_trip: assert property (platformDiagTrip |-> ##[1:6] safeState)
    else $error("diagnostic demand did not trip");
  a_override_wins: assert property ($rose(safetyOverrideKey) |-> ##6 (safeState && fieldOut == 8'h00))
    else $error("override did not force safe outputs");
  a_tuning_safe: assert property (tuningKey |-> ##[1:6] safeState)
    else $error("tuning mode left outputs live");
  a_tuning_gate: assert property ((!tuningKey) [*6] |-> !tuningPortEnable && !tuningAccValid)
    else $error("tuning traffic passed without key");
  a_latch_holds: assert property ($fell(safeState) |-> relAge_q < 4'h8)
    else $error("safe state left without release");
  a_release_blocked: assert property ((!powerGood) [*6] |-> safeState)
    else $error("release taken while trigger active");
  c_released: cover property ($fell(safeState));
  c_tuning_rx: cover property (tuningAccValid);
  c_override: cover property ($rose(safetyOverrideKey));
endmodule // sss_checker
bind sss_safe_state_supervisor sss_checker i_chk (.*);
`default_nettype wire

/* sim/sss_platform_model.sv */
// model of the platform side: startup self-test results, module check, watchdog kicks
// assumes the supervisor's clock; the bench steers faults through kickEn and badModule
`timescale 1ns/10ps
`default_nettype none
module sss_platform_model (
  // clock and steering
  input  wire logic core_clk,
  input  wire logic rst_n,
  input  wire logic kickEn,
  input  wire logic badModule,
  // status toward the supervisor
  output var  logic selfTestDone,
  output var  logic selfTestPass,
  output var  logic configCheckPass,
  output var  logic moduleTypeOk,
  output var  logic wdogKick
);
  logic [5:0] cnt_q;  // cycles since reset, wraps
  logic       done_q; // startup tests finished
  // ----------------------------------------------------------------
  // startup sequence and kick timing
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= 6'h00;
      done_q <= 1'b0;
    end else begin
      cnt_q <= cnt_q + 6'h01;
      if (cnt_q == 6'h1f) done_q <= 1'b1; // tests take some time after power-up
    end
  end
  assign selfTestDone = done_q;
  assign selfTestPass = done_q;
  assign configCheckPass = done_q;
  assign moduleTypeOk = !badModule;
  assign wdogKick = kickEn && cnt_q[2];       // rising edge every 8 cycles
endmodule // sss_platform_model
`default_nettype wire

/* sim/testbench.sv */
// testbench: drives the supervisor through power-up, every trip cause, tuning, substitution
// assumes the platform model supplies startup status and watchdog kicks
`timescale 1ns/10ps
`default_nettype none
module testbench;
  // ----------------------------------------------------------------
  // signals, all inputs valued at time zero
  // ----------------------------------------------------------------
  logic core_clk = 0, rst_n = 0, avsRead = 0, avsWrite = 0, powerGood = 1, supplyAFail = 0;
  logic supplyBFail = 0, severeFault = 0, platformDiagTrip = 0, crcError = 0, safetyOverrideKey = 0;
  logic tuningKey = 0, releaseButton = 0, tuningRxValid = 0, otherRxValid = 0, monitorRxValid = 0;
  logic kickEn = 1, badModule = 0, accSeen = 0;
  logic [3:0] avsAddress = 4'h0, avsByteEnable = 4'hf;
  logic [31:0] avsWriteData = 32'h0;
  logic [7:0] discreteIn = 8'h00, discreteFault = 8'h00, analogIn0 = 8'h00, analogIn1 = 8'h00;
  logic [7:0] tuningRxData = 8'h00, accData = 8'h00;
  logic [1:0] analogFault = 2'h0;
  wire logic selfTestDone, selfTestPass, configCheckPass, moduleTypeOk, wdogKick, avsWaitRequest;
  wire logic tuningAccValid, tuningPortEnable, safeState, supplyAlarm, wdogExpired;
  wire logic [31:0] avsReadData;
  wire logic [7:0] discreteOut, analogOut0, analogOut1, tuningAccData, fieldOut;
  int n_fail = 0, n_tests = 0;
  sss_safe_state_supervisor #(.WDOG_CYCLES(50)) i_sss_safe_state_supervisor (.*);
  sss_platform_model i_sss_platform_model (.*);
  initial begin
    forever #20 core_clk = ~core_clk;
  end
  // catch accepted tuning pulses
  always @(posedge core_clk) begin
    if (tuningAccValid === 1'b1) begin
      accSeen <= 1'b1;
      accData <= tuningAccData;
    end
  end
  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic report_and_stop();
    $display("tests %0d failures %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic waitAck();
    int k;
    k = 0;
    do begin
      @(posedge core_clk);
      k++;
    end while (avsWaitRequest !== 1'b0 && k < 20);
    if (avsWaitRequest !== 1'b0) begin
      n_fail++;
      report_and_stop();
    end
  endtask
  task automatic bw(input logic [3:0] a, input logic [31:0] d);
    avsAddress <= a;
    avsWriteData <= d;
    avsWrite <= 1'b1;
    waitAck();
    avsWrite <= 1'b0;
    @(posedge core_clk);
  endtask
  task automatic br(input logic [3:0] a, input logic [31:0] e);
    avsAddress <= a;
    avsRead <= 1'b1;
    waitAck();
    chk(avsReadData, e);
    avsRead <= 1'b0;
    @(posedge core_clk);
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  task automatic rel();
    releaseButton <= 1'b1;
    tick(3);
    releaseButton <= 1'b0;
    tick(7);
  endtask
  task automatic trig(input int i, input logic v);
    case (i)
      0: powerGood <= !v;
      1: severeFault <= v;
      2: platformDiagTrip <= v;
      3: safetyOverrideKey <= v;
      4: tuningKey <= v;
      5: crcError <= v;
      6: badModule <= v;
      default: bw(4'h0, {31'h0, v});
    endcase
  endtask
  initial begin
    tick(20000);
    n_fail++;
    report_and_stop();
  end
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    int k;
    tick(12);
    rst_n <= 1'b1;
    tick(1);
    chk(safeState, 1);
    br(4'h0, 32'h1); br(4'hc, 32'h3ff); br(4'h2, 32'h0);
    bw(4'h0, 32'h0);
    rel(); chk(safeState, 1);
    bw(4'h8, 32'h5a);
    for (k = 0; k < 100 && selfTestDone !== 1'b1; k++) tick(1);
    rel(); chk(fieldOut, 8'h5a);
    br(4'h4, 32'h40);
    $display("power-up release test done");
    for (int i = 0; i < 8; i++) begin
      trig(i, 1'b1); tick(7);
      chk(safeState, 1);
      chk(fieldOut, 8'h00);
      rel(); chk(safeState, 1);
      trig(i, 1'b0); tick(7);
      chk(safeState, 1);
      if (i == 5) begin rel(); chk(safeState, 1); end
      rel(); chk(fieldOut, 8'h5a);
    end
    $display("trip causes test done");
    tuningRxValid <= 1'b1; otherRxValid <= 1'b1; monitorRxValid <= 1'b1; tuningRxData <= 8'h3c;
    tick(1);
    tuningRxValid <= 1'b0; otherRxValid <= 1'b0; monitorRxValid <= 1'b0; tuningKey <= 1'b1;
    tick(7);
    chk(accSeen, 0);
    chk(tuningPortEnable, 1);
    tuningRxValid <= 1'b1; tuningRxData <= 8'ha5;
    tick(1);
    tuningRxValid <= 1'b0; tuningKey <= 1'b0;
    tick(7);
    chk(accData, 8'ha5);
    rel();
    $display("tuning gate test done");
    discreteIn <= 8'hff; discreteFault <= 8'h0f; analogIn0 <= 8'h80; analogIn1 <= 8'h33; analogFault <= 2'h1;
    supplyAFail <= 1'b1;
    tick(7);
    chk({discreteOut, analogOut0, analogOut1}, 32'hf00033);
    chk({supplyAlarm, safeState}, 2'h2);
    bw(4'hc, 32'h2ff); tick(2);
    chk({discreteOut, analogOut0, analogOut1}, 32'hf08033);
    br(4'hc, 32'h2ff);
    $display("substitution and supply test done");
    kickEn <= 1'b0;
    for (k = 0; k < 200 && safeState !== 1'b1; k++) tick(1);
    chk({wdogExpired, safeState}, 2'h3);
    $display("watchdog test done");
    report_and_stop();
  end
endmodule // testbench
`default_nettype wire

/* src/sss_safe_state_supervisor.v */
// safe-state supervisor inside the logic module: trip latch, safe outputs, input substitution, port gating
// assumes all status pins are asynchronous to core_clk; software reaches registers over Avalon-MM
//
// Our own choices: register access over Avalon-MM and the address map.
`timescale 1ns/10ps
`default_nettype none
`include "sss_map.vh"

module sss_safe_state_supervisor #(
  parameter WDOG_CYCLES = `SSS_WDOG_CYCLES  // watchdog expiry count
) (
  // clock and reset
  input  wire        core_clk,
  input  wire        rst_n,
  // avalon-mm slave
  input  wire [3:0]  avsAddress,
  input  wire        avsRead,
  input  wire        avsWrite,
  input  wire [31:0] avsWriteData,
  input  wire [3:0]  avsByteEnable,
  output reg  [31:0] avsReadData,
  output wire        avsWaitRequest,
  // power and fault status pins
  input  wire        powerGood,
  input  wire        supplyAFail,
  input  wire        supplyBFail,
  input  wire        severeFault,
  input  wire        platformDiagTrip,
  input  wire        selfTestDone,
  input  wire        selfTestPass,
  input  wire        configCheckPass,
  input  wire        moduleTypeOk,
  input  wire        crcError,
  input  wire        wdogKick,
  // keyswitches and release button
  input  wire        safetyOverrideKey,
  input  wire        tuningKey,
  input  wire        releaseButton,
  // field inputs from input cards
  input  wire [7:0]  discreteIn,
  input  wire [7:0]  discreteFault,
  input  wire [7:0]  analogIn0,
  input  wire [7:0]  analogIn1,
  input  wire [1:0]  analogFault,
  // inbound communication
  input  wire        tuningRxValid,
  input  wire [7:0]  tuningRxData,
  input  wire        otherRxValid,
  input  wire        monitorRxValid,
  // processed inputs to application logic
  output reg  [7:0]  discreteOut,
  output reg  [7:0]  analogOut0,
  output reg  [7:0]  analogOut1,
  // accepted tuning data
  output reg         tuningAccValid,
  output reg  [7:0]  tuningAccData,
  output reg         tuningPortEnable,
  // field outputs
  output reg  [7:0]  fieldOut,
  output reg         safeState,
  output reg         supplyAlarm,
  output reg         wdogExpired
);

  // ----------------------------------------------------------------
  // input synchronisers
  // ----------------------------------------------------------------
  localparam NSYNC = 16;
  wire [NSYNC-1:0] rawIn = {releaseButton, tuningKey, safetyOverrideKey, wdogKick, crcError, moduleTypeOk,
                            configCheckPass, selfTestPass, selfTestDone, platformDiagTrip, severeFault,
                            supplyBFail, supplyAFail, powerGood, tuningRxValid, otherRxValid};
  reg  [NSYNC-1:0] sync1_q;       // first stage, read only by second
  reg  [NSYNC-1:0] sync2_q;       // usable copy
  reg  [7:0]       dinS1_q, dinS2_q, dfS1_q, dfS2_q, a0S1_q, a0S2_q, a1S1_q, a1S2_q, rxS1_q, rxS2_q;
  reg  [1:0]       afS1_q, afS2_q;

  // two-flop synchronisers on every status, key, field and rx pin except monitorRxValid
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      sync1_q <= 16'h0000;
      sync2_q <= 16'h0000;
      {dinS1_q, dinS2_q, dfS1_q, dfS2_q} <= 32'h0000_0000;
      {a0S1_q, a0S2_q, a1S1_q, a1S2_q}   <= 32'h0000_0000;
      {rxS1_q, rxS2_q} <= 16'h0000;
      {afS1_q, afS2_q} <= 4'h0;
    end else begin
      sync1_q <= rawIn;
      sync2_q <= sync1_q;
      dinS1_q <= discreteIn;    dinS2_q <= dinS1_q;
      dfS1_q  <= discreteFault; dfS2_q  <= dfS1_q;
      a0S1_q  <= analogIn0;     a0S2_q  <= a0S1_q;
      a1S1_q  <= analogIn1;     a1S2_q  <= a1S1_q;
      rxS1_q  <= tuningRxData;  rxS2_q  <= rxS1_q;
      afS1_q  <= analogFault;   afS2_q  <= afS1_q;
    end
  end

  wire otherRxS   = sync2_q[0];   // monitoring rx is never sampled at all
  wire tuneRxS    = sync2_q[1];
  wire pwrGoodS   = sync2_q[2];
  wire supAS      = sync2_q[3];
  wire supBS      = sync2_q[4];
  wire severeS    = sync2_q[5];
  wire diagS      = sync2_q[6];
  wire stDoneS    = sync2_q[7];
  wire stPassS    = sync2_q[8];
  wire cfgOkS     = sync2_q[9];
  wire modOkS     = sync2_q[10];
  wire crcErrS    = sync2_q[11];
  wire kickS      = sync2_q[12];
  wire sorS       = sync2_q[13];
  wire tuneKeyS   = sync2_q[14];
  wire releaseS   = sync2_q[15];

  // ----------------------------------------------------------------
  // registers and sticky failures
  // ----------------------------------------------------------------
  reg  [31:0] ctrl_q;           // application trip request
  reg  [7:0]  outCmd_q;         // application output command
  reg  [9:0]  subSel_q;         // per-input substitution enable, 8 discrete + 2 analog
  reg         releasePrev_q;    // edge detector for release button
  reg         crcFail_q;        // sticky crc failure
  reg  [31:0] wdogCnt_q;        // cycles since last kick
  reg         kickPrev_q;
  reg         powerUp_q;        // set at reset, cleared by the first release taken with no trigger
  reg         latched_q;        // safe-state latch

  wire kickEdge    = kickS & ~kickPrev_q;
  wire swRelease   = avsWrite & (avsAddress == `SSS_REG_CTRL) & avsByteEnable[0]
                     & avsWriteData[`SSS_CTRL_RELEASE];
  wire releaseEvt  = (releaseS & ~releasePrev_q) | swRelease;
  wire startupOk   = stDoneS & stPassS & cfgOkS & modOkS;

  // any trigger, combined in one term
  wire tripNow = ~pwrGoodS | severeS
                 | ~startupOk | diagS | ctrl_q[`SSS_CTRL_APPTRIP]
                 | sorS
                 | tuneKeyS
                 | wdogExpired | crcFail_q;

  // watchdog counter and crc sticky flag
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      wdogCnt_q   <= 32'h0000_0000;
      kickPrev_q  <= 1'b0;
      wdogExpired <= 1'b0;
      crcFail_q   <= 1'b0;
    end else begin
      kickPrev_q <= kickS;
      if (kickEdge) begin
        wdogCnt_q <= 32'h0000_0000;
      end else if (wdogCnt_q < WDOG_CYCLES) begin
        wdogCnt_q <= wdogCnt_q + 32'h0000_0001;
      end
      // expiry sticks until a release lands in the same cycle as a kick edge; set wins over clear
      if (wdogCnt_q >= WDOG_CYCLES - 1) begin
        wdogExpired <= 1'b1;
      end else if (releaseEvt && kickEdge) begin
        wdogExpired <= 1'b0;
      end
      if (crcErrS) begin
        crcFail_q <= 1'b1;
      end else if (releaseEvt) begin
        crcFail_q <= 1'b0;
      end
    end
  end

  // safe-state latch: set in one cycle, cleared only by release with no trigger
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      latched_q     <= 1'b1;
      powerUp_q     <= 1'b1;
      releasePrev_q <= 1'b0;
    end else begin
      releasePrev_q <= releaseS;
      if (tripNow) begin
        latched_q <= 1'b1;
      end else if (releaseEvt) begin
        latched_q <= 1'b0;
        powerUp_q <= 1'b0;
      end
    end
  end

  // field outputs and supply annunciation
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      fieldOut    <= 8'h00;
      safeState   <= 1'b1;
      supplyAlarm <= 1'b0;
    end else begin
      safeState   <= latched_q | tripNow;
      // de-energized is the safe level; override beats every command
      fieldOut    <= (latched_q | tripNow) ? 8'h00 : outCmd_q;
      supplyAlarm <= supAS ^ supBS;
    end
  end

  // ----------------------------------------------------------------
  // input substitution and communication gating
  // ----------------------------------------------------------------
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      discreteOut      <= 8'h00;
      analogOut0       <= 8'h00;
      analogOut1       <= 8'h00;
      tuningAccValid   <= 1'b0;
      tuningAccData    <= 8'h00;
      tuningPortEnable <= 1'b0;
    end else begin
      // faulted discrete reads open contact when selected
      discreteOut <= dinS2_q & ~(dfS2_q & subSel_q[7:0]);
      analogOut0  <= (afS2_q[0] & subSel_q[8]) ? 8'h00 : a0S2_q;
      analogOut1  <= (afS2_q[1] & subSel_q[9]) ? 8'h00 : a1S2_q;
      tuningPortEnable <= tuneKeyS;
      // other and monitoring inbound are dropped
      tuningAccValid <= tuneKeyS & tuneRxS;
      if (tuneKeyS & tuneRxS) begin
        tuningAccData <= rxS2_q;
      end
    end
  end

  // ----------------------------------------------------------------
  // avalon-mm register file
  // ----------------------------------------------------------------
  reg         rdValid_q;        // read data loaded, request may complete

  // writes complete at once; a read waits one cycle so that the registered data stand when released
  assign avsWaitRequest = avsRead & ~rdValid_q;

  // register writes
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_q   <= `SSS_CTRL_RESET;
      outCmd_q <= 8'h00;
      subSel_q <= 10'h3ff;
    end else if (avsWrite) begin
      case (avsAddress)
        `SSS_REG_CTRL:   if (avsByteEnable[0]) ctrl_q[`SSS_CTRL_APPTRIP] <= avsWriteData[`SSS_CTRL_APPTRIP];
        `SSS_REG_OUTCMD: if (avsByteEnable[0]) outCmd_q <= avsWriteData[7:0];
        `SSS_REG_SUBSEL: begin
          if (avsByteEnable[0]) subSel_q[7:0] <= avsWriteData[7:0];
          if (avsByteEnable[1]) subSel_q[9:8] <= avsWriteData[9:8];
        end
        default: ;
      endcase
    end
  end

  // read data registered in the wait cycle, then held while waitrequest is low
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      avsReadData <= 32'h0000_0000;
      rdValid_q   <= 1'b0;
    end else begin
      // one pulse per read request; drops at the completing edge so a back-to-back read waits again
      rdValid_q <= avsRead & ~rdValid_q;
      if (avsRead & ~rdValid_q) begin
      case (avsAddress)
        `SSS_REG_CTRL:   avsReadData <= {31'h0, ctrl_q[`SSS_CTRL_APPTRIP]};
        `SSS_REG_STATUS: avsReadData <= {25'h0, startupOk & ~powerUp_q, tuneKeyS, crcFail_q, wdogExpired,
                                         supplyAlarm, tripNow, latched_q};
        `SSS_REG_OUTCMD: avsReadData <= {24'h0, outCmd_q};
        `SSS_REG_SUBSEL: avsReadData <= {22'h0, subSel_q};
        default:         avsReadData <= 32'h0000_0000;
      endcase
      end
    end
  end

  wire unusedRx = otherRxS | monitorRxValid | otherRxValid | (|avsWriteData[31:10]) | (|avsByteEnable[3:2]);

endmodule // sss_safe_state_supervisor
`default_nettype wire
